// File: hdl/exec_slice.sv
// Execution slice: add, and, branch on carry, bit clear
// Behaviour
// - Add immediate: accumulator plus low-byte literal into accumulator.
// - Add to file: accumulator plus addressed register.
// - Destination bit 0 writes accumulator, 1 writes file register.
// - Bank bit 0 uses direct bank; 1 uses bank pointer.
// - Add with carry: accumulator, register and carry to destination.
// - Every add updates negative, wrap, carry, nibble-carry and zero flags.
// - And immediate: accumulator AND literal, only N and Z updated.
// - And with file: result to destination, only N and Z updated.
// - Branch on carry branches only when carry is one; flags kept.
// - Offset is signed -128..127 and doubled.
// - Taken branch: PC = branch address + 2 + 2n, two cycles.
// - Bit clear clears indexed bit of addressed register, no flags.
// - Add to file with bank bit 1 uses bank pointer.
// - A taken branch adds one no-operation cycle.
`timescale 1ns/1ps
module exec_slice
    import exec_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              rst_n,
    input  wire logic [15:0]       instr,
    input  wire logic [BANK_W-1:0] bank_pointer,
    input  wire logic [DATA_W-1:0] file_rdata,
    output logic      [ADDR_W-1:0] file_addr,
    output logic      [DATA_W-1:0] file_wdata,
    output logic                   file_we,
    output logic      [DATA_W-1:0] accumulator,
    output logic      [FLG_W-1:0]  status,
    output logic      [PC_W-1:0]   pc,
    output logic                   fetch,
    output logic      [3:0]        phase
);
    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic [ADDR_W-1:0] file_address(
        input logic [15:0] ins, input logic [BANK_W-1:0] bp);
        logic [BANK_W-1:0] bank;
        bank = bp;
        if (!ins[BANK_BIT]) begin
            bank = (ins[7:0] >= DIRECT_SPLIT) ? DIRECT_HI_BANK : 4'h0;
        end
        return {bank, ins[7:0]};
    endfunction : file_address

    function automatic logic [PC_W-1:0] branch_target(
        input logic [PC_W-1:0] base, input logic [7:0] n);
        logic [PC_W-1:0] off;
        off = {{(PC_W-9){n[7]}}, n, 1'b0};
        return base + PC_STEP + off;
    endfunction : branch_target

    // ****************************************
    // Phase sequencer and state
    // ****************************************
    phase_t            ph;
    phase_t            next_ph;
    logic [15:0]       ir;
    logic [15:0]       next_ir;
    logic [DATA_W-1:0] opnd;
    logic [DATA_W-1:0] next_opnd;
    logic [DATA_W-1:0] res;
    logic [DATA_W-1:0] next_res;
    logic [FLG_W-1:0]  rflags;
    logic [FLG_W-1:0]  next_rflags;
    logic              bubble;
    logic              next_bubble;
    logic [DATA_W-1:0] next_accumulator;
    logic [FLG_W-1:0]  next_status;
    logic [PC_W-1:0]   next_pc;
    logic [ADDR_W-1:0] next_file_addr;
    logic [DATA_W-1:0] next_file_wdata;
    logic              next_file_we;
    logic              next_fetch;

    logic is_addi, is_andi, is_brc, is_addf, is_addcf, is_andf, is_bclr;
    logic is_filew;

    logic [DATA_W-1:0] alu_res;
    logic [FLG_W-1:0]  alu_flags;
    logic              use_carry;
    logic              do_and;

    always_comb begin
        is_addi  = ir[15:8] == OP_ADD_IMM;
        is_andi  = ir[15:8] == OP_AND_IMM;
        is_brc   = ir[15:8] == OP_BR_C;
        is_addf  = ir[15:10] == OP_ADD_F;
        is_addcf = ir[15:10] == OP_ADDC_F;
        is_andf  = ir[15:10] == OP_AND_F;
        is_bclr  = ir[15:12] == OP_BCLR;
        is_filew = is_addf | is_addcf | is_andf;
        use_carry = is_addcf;
        do_and    = is_andi | is_andf;
    end

    exec_alu u_alu (
        .acc       (accumulator),
        .operand   (opnd),
        .carry_in  (status[FLG_C]),
        .use_carry (use_carry),
        .do_and    (do_and),
        .result    (alu_res),
        .flags     (alu_flags)
    );

    always_comb begin
        next_ph          = ph;
        next_ir          = ir;
        next_opnd        = opnd;
        next_res         = res;
        next_rflags      = rflags;
        next_bubble      = bubble;
        next_accumulator = accumulator;
        next_status      = status;
        next_pc          = pc;
        next_file_addr   = file_addr;
        next_file_wdata  = file_wdata;
        next_file_we     = 1'b0;
        next_fetch       = 1'b0;
        case (ph)
            PH_DECODE: begin
                next_ph = PH_READ;
                if (!bubble) begin
                    next_ir        = instr;
                    next_file_addr = file_address(instr, bank_pointer);
                end
            end
            PH_READ: begin
                next_ph = PH_PROCESS;
                if (is_addi || is_andi) begin
                    next_opnd = ir[7:0];
                end else begin
                    next_opnd = file_rdata;
                end
            end
            PH_PROCESS: begin
                next_ph     = PH_WRITE;
                next_rflags = alu_flags;
                if (is_bclr) begin
                    next_res = opnd & ~(8'h01 << ir[BIDX_LSB +: 3]);
                end else begin
                    next_res = alu_res;
                end
            end
            PH_WRITE: begin
                next_ph     = PH_DECODE;
                next_fetch  = 1'b1;
                next_bubble = 1'b0;
                next_pc     = pc + PC_STEP;
                if (bubble) begin
                    next_pc = pc;
                end else if (is_brc) begin
                    if (status[FLG_C]) begin
                        next_pc     = branch_target(pc, ir[7:0]);
                        next_bubble = 1'b1;
                    end
                end else if (is_addi || is_andi) begin
                    next_accumulator = res;
                end else if (is_filew || is_bclr) begin
                    if (is_filew && !ir[DEST_BIT]) begin
                        next_accumulator = res;
                    end else begin
                        next_file_wdata = res;
                        next_file_we    = 1'b1;
                    end
                end
                if (!bubble) begin
                    if (is_addi || is_addf || is_addcf) begin
                        next_status = rflags;
                    end else if (is_andi || is_andf) begin
                        next_status[FLG_N] = rflags[FLG_N];
                        next_status[FLG_Z] = rflags[FLG_Z];
                    end
                end
            end
            default: next_ph = PH_DECODE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ph          <= PH_DECODE;
            ir          <= 16'h0000;
            opnd        <= ACC_RESET;
            res         <= ACC_RESET;
            rflags      <= FLAG_RESET;
            bubble      <= 1'b0;
            accumulator <= ACC_RESET;
            status      <= FLAG_RESET;
            pc          <= PC_RESET;
            file_addr   <= '0;
            file_wdata  <= ACC_RESET;
            file_we     <= 1'b0;
            fetch       <= 1'b0;
            phase       <= PH_DECODE;
        end else begin
            ph          <= next_ph;
            ir          <= next_ir;
            opnd        <= next_opnd;
            res         <= next_res;
            rflags      <= next_rflags;
            bubble      <= next_bubble;
            accumulator <= next_accumulator;
            status      <= next_status;
            pc          <= next_pc;
            file_addr   <= next_file_addr;
            file_wdata  <= next_file_wdata;
            file_we     <= next_file_we;
            fetch       <= next_fetch;
            phase       <= next_ph;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_phase_order;
        @(posedge sys_clk) disable iff (!rst_n)
        ph == PH_DECODE |=> ph == PH_READ ##1 ph == PH_PROCESS
            ##1 ph == PH_WRITE ##1 ph == PH_DECODE;
    endproperty
    a_phase_order: assert property (p_phase_order)
        else $error("phase order broken");

    property p_addi;
        @(posedge sys_clk) disable iff (!rst_n)
        ph == PH_WRITE && !bubble && is_addi |=>
            accumulator == 8'($past(accumulator) + $past(ir[7:0]))
            && status[FLG_Z] == (accumulator == 8'h00);
    endproperty
    a_addi: assert property (p_addi)
        else $error("add immediate result lost");

    property p_dest_acc;
        @(posedge sys_clk) disable iff (!rst_n)
        ph == PH_WRITE && !bubble && is_filew && !ir[DEST_BIT] |=>
            accumulator == $past(res) && !file_we;
    endproperty
    a_dest_acc: assert property (p_dest_acc)
        else $error("destination accumulator not honoured");

    property p_dest_file;
        @(posedge sys_clk) disable iff (!rst_n)
        ph == PH_WRITE && !bubble && (is_bclr || (is_filew && ir[DEST_BIT]))
            |=> file_we && file_wdata == $past(res);
    endproperty
    a_dest_file: assert property (p_dest_file)
        else $error("file write missing");

    property p_bank;
        @(posedge sys_clk) disable iff (!rst_n)
        ph == PH_DECODE && !bubble && instr[BANK_BIT] |=>
            file_addr == {$past(bank_pointer), $past(instr[7:0])};
    endproperty
    a_bank: assert property (p_bank)
        else $error("bank pointer not used for address");

    property p_and_flags;
        @(posedge sys_clk) disable iff (!rst_n)
        ph == PH_WRITE && !bubble && (is_andi || is_andf) |=>
            status[FLG_C] == $past(status[FLG_C])
            && status[FLG_WRAP] == $past(status[FLG_WRAP]);
    endproperty
    a_and_flags: assert property (p_and_flags)
        else $error("and changed arithmetic flags");

    property p_brc_taken;
        @(posedge sys_clk) disable iff (!rst_n)
        ph == PH_WRITE && !bubble && is_brc && status[FLG_C] |=>
            bubble && status == $past(status)
            && pc == $past(pc) + PC_STEP
               + {{(PC_W-9){$past(ir[7])}}, $past(ir[7:0]), 1'b0};
    endproperty
    a_brc_taken: assert property (p_brc_taken)
        else $error("taken branch target wrong");

    property p_brc_not;
        @(posedge sys_clk) disable iff (!rst_n)
        ph == PH_WRITE && !bubble && is_brc && !status[FLG_C] |=>
            !bubble && pc == $past(pc) + PC_STEP;
    endproperty
    a_brc_not: assert property (p_brc_not)
        else $error("untaken branch moved wrong");

    property p_bubble_nop;
        @(posedge sys_clk) disable iff (!rst_n)
        bubble && ph == PH_WRITE |=> !file_we && $stable(accumulator)
            && $stable(status) && $stable(pc);
    endproperty
    a_bubble_nop: assert property (p_bubble_nop)
        else $error("bubble cycle did work");

    c_addi:  cover property (@(posedge sys_clk) ph == PH_WRITE && is_addi);
    c_taken: cover property (@(posedge sys_clk) bubble && ph == PH_WRITE);
    c_bclr:  cover property (@(posedge sys_clk) file_we && is_bclr);
    c_addc:  cover property (@(posedge sys_clk)
        ph == PH_WRITE && is_addcf && status[FLG_C]);
endmodule : exec_slice

// File: hdl/exec_pkg.sv
// Package: opcodes, flag positions, phase codes and widths for the exec slice
package exec_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W   = 21;
    localparam int ADDR_W = 12;
    localparam int BANK_W = 4;

    // Opcode patterns on the upper bits of the instruction word
    localparam logic [7:0] OP_ADD_IMM = 8'h0f;
    localparam logic [7:0] OP_AND_IMM = 8'h0b;
    localparam logic [7:0] OP_BR_C    = 8'he2;
    localparam logic [5:0] OP_ADD_F   = 6'h09;
    localparam logic [5:0] OP_ADDC_F  = 6'h08;
    localparam logic [5:0] OP_AND_F   = 6'h05;
    localparam logic [3:0] OP_BCLR    = 4'h9;

    // Instruction field positions
    localparam int DEST_BIT  = 9;
    localparam int BANK_BIT  = 8;
    localparam int BIDX_LSB  = 9;

    // Status flag positions
    localparam int FLG_C  = 0;
    localparam int FLG_NIBC = 1;
    localparam int FLG_Z  = 2;
    localparam int FLG_WRAP = 3;
    localparam int FLG_N  = 4;
    localparam int FLG_W  = 5;

    // Direct bank: low half low RAM, high half special registers
    localparam logic [3:0] DIRECT_HI_BANK = 4'hf;
    localparam logic [7:0] DIRECT_SPLIT   = 8'h80;

    localparam logic [DATA_W-1:0] ACC_RESET  = 8'h00;
    localparam logic [FLG_W-1:0]  FLAG_RESET = 5'h00;
    localparam logic [PC_W-1:0]   PC_RESET   = 21'h000000;
    localparam logic [PC_W-1:0]   PC_STEP    = 21'h000002;

    // Phases of one instruction cycle, one-hot
    typedef enum logic [3:0] {
        PH_DECODE  = 4'b0001,
        PH_READ    = 4'b0010,
        PH_PROCESS = 4'b0100,
        PH_WRITE   = 4'b1000
    } phase_t;
endpackage : exec_pkg

// File: hdl/exec_alu.sv
// Combinational arithmetic and logic unit of the exec slice
`timescale 1ns/1ps
module exec_alu
    import exec_pkg::*;
(
    input  wire logic [DATA_W-1:0] acc,
    input  wire logic [DATA_W-1:0] operand,
    input  wire logic              carry_in,
    input  wire logic              use_carry,
    input  wire logic              do_and,
    output logic      [DATA_W-1:0] result,
    output logic      [FLG_W-1:0]  flags
);
    logic [DATA_W:0] sum;
    logic [4:0]      low_sum;
    logic            cin;

    always_comb begin
        cin     = use_carry & carry_in;
        sum     = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
        low_sum = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
        flags   = '0;
        if (do_and) begin
            result = acc & operand;
        end else begin
            result         = sum[DATA_W-1:0];
            flags[FLG_C]   = sum[DATA_W];
            flags[FLG_NIBC] = low_sum[4];
            flags[FLG_WRAP] = (acc[7] == operand[7]) && (result[7] != acc[7]);
        end
        flags[FLG_Z] = (result == 8'h00);
        flags[FLG_N] = result[7];
    end
endmodule : exec_alu

// File: bench/exec_mem_model.sv
// File register and program memory model facing the exec slice
`timescale 1ns/1ps
module exec_mem_model
    import exec_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic [ADDR_W-1:0] file_addr,
    input  wire logic [DATA_W-1:0] file_wdata,
    input  wire logic              file_we,
    input  wire logic [PC_W-1:0]   pc,
    output logic      [DATA_W-1:0] file_rdata,
    output logic      [15:0]       instr
);
    // Bench preloads both arrays directly
    logic [DATA_W-1:0] fmem [0:4095];
    logic [15:0]       prog [0:31];

    assign file_rdata = fmem[file_addr];
    assign instr      = prog[pc[5:1]];

    always @(posedge sys_clk) begin
        if (file_we === 1'b1) begin
            fmem[file_addr] <= file_wdata;
        end
    end
endmodule : exec_mem_model

// File: bench/exec_slice_tb_top.sv
// Self-checking bench for the exec slice
`timescale 1ns/1ps
module exec_slice_tb_top
    import exec_pkg::*;
;
    logic              sys_clk;
    logic              rst_n;
    logic [BANK_W-1:0] bank_pointer;
    logic [15:0]       instr;
    logic [DATA_W-1:0] file_rdata;
    logic [ADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] file_wdata;
    logic              file_we;
    logic [DATA_W-1:0] accumulator;
    logic [FLG_W-1:0]  status;
    logic [PC_W-1:0]   pc;
    logic [3:0]        phase;
    logic              fetch;
    int                bad_count;
    int                tests_run;

    exec_slice u_dut (
        .sys_clk      (sys_clk),
        .rst_n        (rst_n),
        .instr        (instr),
        .bank_pointer (bank_pointer),
        .file_rdata   (file_rdata),
        .file_addr    (file_addr),
        .file_wdata   (file_wdata),
        .file_we      (file_we),
        .accumulator  (accumulator),
        .status       (status),
        .pc           (pc),
        .fetch        (fetch),
        .phase        (phase)
    );

    exec_mem_model u_mem (
        .sys_clk    (sys_clk),
        .file_addr  (file_addr),
        .file_wdata (file_wdata),
        .file_we    (file_we),
        .pc         (pc),
        .file_rdata (file_rdata),
        .instr      (instr)
    );

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // ***************************************
    // Helpers
    // ***************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : step

    // Holds reset and clears the program
    task automatic reset_on(input logic [3:0] bp);
        @(posedge sys_clk);
        rst_n        <= 1'b0;
        bank_pointer <= bp;
        @(posedge sys_clk);
        for (int i = 0; i < 32; i++) begin
            u_mem.prog[i] = 16'h0000;
        end
    endtask : reset_on

    task automatic reset_off();
        @(posedge sys_clk);
        rst_n <= 1'b1;
        #1;
    endtask : reset_off

    // ***************************************
    // Scenarios
    // ***************************************
    task automatic t_add_branch_taken();
        reset_on(4'h0);
        u_mem.prog[0] = 16'h0f10;
        u_mem.prog[1] = 16'h0f15;
        u_mem.prog[2] = 16'h0ff0;
        u_mem.prog[3] = 16'he202;
        u_mem.prog[4] = 16'h0f01;
        u_mem.prog[5] = 16'h0f01;
        u_mem.prog[6] = 16'h0b05;
        reset_off();
        chk(32'(phase), 32'h1);
        chk(32'(fetch), 32'h0);
        step(1);
        chk(32'(phase), 32'h2);
        step(1);
        chk(32'(phase), 32'h4);
        step(1);
        chk(32'(phase), 32'h8);
        step(1);
        chk(32'(accumulator), 32'h10);
        chk(32'(pc), 32'h2);
        chk(32'(fetch), 32'h1);
        step(8);
        chk(32'(accumulator), 32'h15);
        chk(32'(status), 32'h01);
        step(8);
        chk(32'(pc), 32'hc);
        chk(32'(accumulator), 32'h15);
        chk(32'(status), 32'h01);
        step(4);
        chk(32'(accumulator), 32'h05);
        chk(32'(status), 32'h01);
        chk(32'(pc), 32'he);
    endtask : t_add_branch_taken

    task automatic t_branch_back();
        reset_on(4'h0);
        u_mem.prog[0] = 16'he2fe;
        u_mem.prog[1] = 16'h0f80;
        u_mem.prog[2] = 16'h0f80;
        u_mem.prog[3] = 16'he2fc;
        reset_off();
        step(4);
        chk(32'(pc), 32'h2);
        step(4);
        chk(32'(status), 32'h10);
        step(4);
        chk(32'(accumulator), 32'h00);
        chk(32'(status), 32'h0d);
        step(8);
        chk(32'(pc), 32'h0);
        chk(32'(status), 32'h0d);
    endtask : t_branch_back

    task automatic t_file_ops();
        reset_on(4'h3);
        u_mem.fmem[12'h3c0] = 8'hc2;
        u_mem.fmem[12'h020] = 8'h02;
        u_mem.fmem[12'hf90] = 8'hf0;
        u_mem.fmem[12'h0c0] = 8'h55;
        u_mem.prog[0] = 16'h0f17;
        u_mem.prog[1] = 16'h25c0;
        u_mem.prog[2] = 16'h0f30;
        u_mem.prog[3] = 16'h2220;
        u_mem.prog[4] = 16'h1690;
        u_mem.prog[5] = 16'h9fc0;
        reset_off();
        step(8);
        chk(32'(accumulator), 32'hd9);
        chk(32'(status), 32'h10);
        step(8);
        chk(32'(accumulator), 32'h09);
        chk(32'(status), 32'h00);
        chk(32'(file_we), 32'h1);
        chk(32'(file_wdata), 32'h0c);
        chk(32'(file_addr), 32'h020);
        step(8);
        chk(32'(u_mem.fmem[12'h3c0]), 32'hc2);
        chk(32'(u_mem.fmem[12'h020]), 32'h0c);
        chk(32'(u_mem.fmem[12'hf90]), 32'h00);
        chk(32'(status), 32'h04);
        step(4);
        chk(32'(u_mem.fmem[12'h3c0]), 32'h42);
        chk(32'(u_mem.fmem[12'h0c0]), 32'h55);
        chk(32'(status), 32'h04);
        chk(32'(accumulator), 32'h09);
        chk(32'(pc), 32'he);
        chk(32'(file_wdata), 32'h42);
    endtask : t_file_ops

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        bad_count    = 0;
        tests_run    = 0;
        rst_n        = 1'b0;
        bank_pointer = 4'h0;
        repeat (16) @(posedge sys_clk);
        t_add_branch_taken();
        t_branch_back();
        t_file_ops();
        report_and_stop();
    end
endmodule : exec_slice_tb_top
